// [ldgd_ctrl_model.sv]
/*
  Model of the external dimming controller that drives the four dimming pins.
  Assumes the block samples its pins on the rising edge of i_clock.
*/
`timescale 1ns/1ps
module ldgd_ctrl_model (
  input wire logic i_clock,
  output logic o_pin_a,
  output logic o_pin_b,
  output logic o_pin_c,
  output logic o_pin_d
);
  // ******************************************************************
  // Pin drivers, changed on the falling edge
  // ******************************************************************
  // Idle pins sit at the pull-down level
  initial begin
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
    o_pin_c = 1'b0;
    o_pin_d = 1'b0;
  end

  task automatic drive_direct(input logic [3:0] v);
    @(negedge i_clock);
    {o_pin_d, o_pin_c, o_pin_b, o_pin_a} = v;
  endtask

  // Data set while the bit clock is low, held through its rise
  task automatic shift_word(input logic [31:0] w);
    o_pin_d = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      @(negedge i_clock);
      o_pin_a = w[i];
      o_pin_b = 1'b0;
      @(negedge i_clock);
      o_pin_b = 1'b1;
    end
    @(negedge i_clock);
    o_pin_a = 1'b0;
    o_pin_b = 1'b0;
  endtask

  task automatic end_frame();
    @(negedge i_clock);
    o_pin_c = 1'b1;
    @(negedge i_clock);
    o_pin_c = 1'b0;
  endtask
endmodule

// [ldgd_dimming.sv]
/*
  LED group dimming control: direct, serial and DC dimming of four channel
  groups driving six channel enables, plus a cascade serial output.
  Assumes all inputs are synchronous to i_clock and that converted DC levels
  arrive as 8-bit duty codes from an external converter.
*/
`timescale 1ns/1ps
module ldgd_dimming import ldgd_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_mode_strap,
  input wire logic i_group_a_dimming_input,
  input wire logic i_group_b_dimming_input,
  input wire logic i_group_c_dimming_input,
  input wire logic i_group_d_dimming_input,
  input wire ldgd_duty_type i_dc_level,
  output logic [5:0] o_channel_on,
  output logic o_sync_out,
  output logic o_cascade_clock_output,
  output logic o_serial_ready
);
  generate
    if (FIFO_DEPTH < 2) begin : g_bad
      $error("ldgd_dimming: FIFO_DEPTH too small");
    end
  endgenerate

  // ******************************************************************
  // Duty compare
  // ******************************************************************
  function automatic logic duty_on(input logic [7:0] code, input logic [7:0] cnt);
    logic [8:0] on_cnt;
    on_cnt = 9'h000;
    if (code == DUTY_RESET) begin
      on_cnt = 9'h000;
    end else if (code == CODE_TWO) begin
      on_cnt = 9'h002;
    end else begin
      on_cnt = {1'b0, code} + 9'h001;
    end
    return ({1'b0, cnt} < on_cnt);
  endfunction

  ldgd_state_type st;
  ldgd_state_type next_st;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_data;
  logic fifo_pop;
  logic clk_rise;
  logic eof_fall;
  logic [3:0] grp_on;

  // In serial mode the pins change role
  assign clk_rise = (st.mode == MODE_SERIAL) && i_group_b_dimming_input && !st.prev_clk;
  assign eof_fall = (st.mode == MODE_SERIAL) && !i_group_c_dimming_input && st.prev_eof;
  assign fifo_pop = !st.casc_busy && (st.mode == MODE_SERIAL);

  // ******************************************************************
  // Cascade buffer
  // ******************************************************************
  // Bits that arrive while the buffer is full are still used locally but
  // are lost to the next unit; o_serial_ready warns the controller.
  ldgd_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_valid(clk_rise),
    .i_data(i_group_a_dimming_input),
    .o_ready(fifo_in_ready),
    .o_valid(fifo_out_valid),
    .o_data(fifo_out_data),
    .i_ready(fifo_pop)
  );

  // ******************************************************************
  // Next state
  // ******************************************************************
  always_comb begin
    next_st = st;
    grp_on = 4'h0;
    next_st.pwm_cnt = st.pwm_cnt + 8'h01;
    next_st.prev_clk = i_group_b_dimming_input;
    next_st.prev_eof = i_group_c_dimming_input;
    next_st.serial_ready = fifo_in_ready;

    case (st.mode)
      MODE_DIRECT: begin
        // Inputs carry the waveform itself; a floating pin reads low
        grp_on = {i_group_d_dimming_input, i_group_c_dimming_input,
                  i_group_b_dimming_input, i_group_a_dimming_input};
      end
      MODE_SERIAL: begin
        if (clk_rise) begin
          next_st.shift = {st.shift[FRAME_BITS-2:0], i_group_a_dimming_input};
        end
        if (eof_fall) begin
          next_st.duty.a = st.shift[BYTE_A_MSB -: 8];
          next_st.duty.b = st.shift[BYTE_B_MSB -: 8];
          next_st.duty.c = st.shift[BYTE_C_MSB -: 8];
          next_st.duty.d = st.shift[BYTE_D_MSB -: 8];
        end
        grp_on = {duty_on(st.duty.d, st.pwm_cnt), duty_on(st.duty.c, st.pwm_cnt),
                  duty_on(st.duty.b, st.pwm_cnt), duty_on(st.duty.a, st.pwm_cnt)};
      end
      MODE_DC: begin
        // Update rate is 1280 cycles while the PWM period stays 256
        if (st.dc_cnt == DC_LAST) begin
          next_st.dc_cnt = 11'h000;
          next_st.duty = i_dc_level;
        end else begin
          next_st.dc_cnt = st.dc_cnt + 11'h001;
        end
        grp_on = {duty_on(st.duty.d, st.pwm_cnt), duty_on(st.duty.c, st.pwm_cnt),
                  duty_on(st.duty.b, st.pwm_cnt), duty_on(st.duty.a, st.pwm_cnt)};
      end
      default: begin
        grp_on = 4'h0;
      end
    endcase

    next_st.chan_on = {grp_on[3], grp_on[2], grp_on[1], grp_on[1],
                       grp_on[0], grp_on[0]};

    // Cascade output: data set with clock low, rises mid-bit
    if (fifo_pop && fifo_out_valid) begin
      next_st.casc_busy = 1'b1;
      next_st.casc_cnt = 4'h0;
      next_st.sync_out = fifo_out_data;
      next_st.casc_clk = 1'b0;
    end else if (st.casc_busy) begin
      next_st.casc_cnt = st.casc_cnt + 4'h1;
      if (st.casc_cnt == CASC_RISE) begin
        next_st.casc_clk = 1'b1;
      end
      if (st.casc_cnt == CASC_LAST) begin
        next_st.casc_clk = 1'b0;
        next_st.casc_busy = 1'b0;
      end
    end
  end

  // ******************************************************************
  // State register
  // ******************************************************************
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      st <= '0;
      st.duty <= '{a: DUTY_RESET, b: DUTY_RESET, c: DUTY_RESET, d: DUTY_RESET};
      // Strap sampled by the clock throughout reset; held afterwards
      if (i_mode_strap == STRAP_OPEN) begin
        st.mode <= MODE_SERIAL;
      end else if (i_mode_strap == STRAP_VCC) begin
        st.mode <= MODE_DC;
      end else begin
        st.mode <= MODE_DIRECT;
      end
    end else begin
      st <= next_st;
    end
  end

  assign o_channel_on = st.chan_on;
  assign o_sync_out = st.sync_out;
  assign o_cascade_clock_output = st.casc_clk;
  assign o_serial_ready = st.serial_ready;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  sequence s_pop;
    fifo_pop && fifo_out_valid;
  endsequence
  sequence s_casc_bit;
    !o_cascade_clock_output [*8] ##1 o_cascade_clock_output [*8];
  endsequence

  property p_mode_strap;
    @(posedge i_clock) $fell(i_sys_rst) |->
      (($past(i_mode_strap) == STRAP_OPEN) == (st.mode == MODE_SERIAL)) &&
      (($past(i_mode_strap) == STRAP_VCC) == (st.mode == MODE_DC));
  endproperty
  a_mode_strap: assert property (p_mode_strap) else $error("mode not taken from strap");

  property p_direct;
    @(posedge i_clock) disable iff (i_sys_rst) (st.mode == MODE_DIRECT) |=>
      o_channel_on == {$past(i_group_d_dimming_input), $past(i_group_c_dimming_input),
                       {2{$past(i_group_b_dimming_input)}}, {2{$past(i_group_a_dimming_input)}}};
  endproperty
  a_direct: assert property (p_direct) else $error("direct output mismatch");

  property p_pairs;
    @(posedge i_clock) disable iff (i_sys_rst)
      (o_channel_on[0] == o_channel_on[1]) && (o_channel_on[2] == o_channel_on[3]);
  endproperty
  a_pairs: assert property (p_pairs) else $error("paired channels differ");

  property p_shift;
    @(posedge i_clock) disable iff (i_sys_rst) clk_rise |=>
      st.shift == {$past(st.shift[FRAME_BITS-2:0]), $past(i_group_a_dimming_input)};
  endproperty
  a_shift: assert property (p_shift) else $error("serial bit not captured");

  property p_load;
    @(posedge i_clock) disable iff (i_sys_rst) eof_fall |=>
      st.duty == $past(st.shift);
  endproperty
  a_load: assert property (p_load) else $error("frame not loaded on end of frame");

  property p_zero_full;
    @(posedge i_clock) disable iff (i_sys_rst) (st.mode != MODE_DIRECT) |=>
      ($past(st.duty.a) == DUTY_RESET |-> !o_channel_on[0]) and
      ($past(st.duty.a) == DUTY_FULL |-> o_channel_on[0]);
  endproperty
  a_zero_full: assert property (p_zero_full) else $error("zero or full duty wrong");

  property p_min_duty;
    @(posedge i_clock) disable iff (i_sys_rst)
      (st.mode != MODE_DIRECT) && (st.duty.c == CODE_ONE || st.duty.c == CODE_TWO) &&
      (st.pwm_cnt == 8'h01) ##1 (st.duty.c == $past(st.duty.c)) |=>
      !o_channel_on[4] && $past(o_channel_on[4]);
  endproperty
  a_min_duty: assert property (p_min_duty) else $error("codes one/two not 2/256");

  property p_counter;
    @(posedge i_clock) disable iff (i_sys_rst) 1'b1 |=> st.pwm_cnt == $past(st.pwm_cnt) + 8'h01;
  endproperty
  a_counter: assert property (p_counter) else $error("pwm counter not free running");

  property p_dc_update;
    @(posedge i_clock) disable iff (i_sys_rst)
      (st.mode == MODE_DC) && (st.dc_cnt == DC_LAST) |=>
      (st.duty == $past(i_dc_level)) && (st.dc_cnt == 11'h000);
  endproperty
  a_dc_update: assert property (p_dc_update) else $error("dc duty not resampled");

  property p_reset_duty;
    @(posedge i_clock) $fell(i_sys_rst) |-> (st.duty == '0) && (o_channel_on == 6'h00);
  endproperty
  a_reset_duty: assert property (p_reset_duty) else $error("duty not zero after reset");

  property p_cascade;
    @(posedge i_clock) disable iff (i_sys_rst) s_pop |=>
      (o_sync_out == $past(fifo_out_data)) and s_casc_bit;
  endproperty
  a_cascade: assert property (p_cascade) else $error("cascade bit not shifted out");
endmodule

// [ldgd_fifo.sv]
/*
  Shared definitions for the LED group dimming block, and the small FIFO that
  buffers received serial bits on their way to the cascade output.
  Assumes one clock and a synchronous, active-high reset.
*/
package ldgd_pkg;
  // ******************************************************************
  // Mode strap and mode states
  // ******************************************************************
  localparam logic [1:0] STRAP_GND = 2'h0;
  localparam logic [1:0] STRAP_OPEN = 2'h1;
  localparam logic [1:0] STRAP_VCC = 2'h2;

  typedef enum logic [2:0] {
    MODE_DIRECT = 3'h1,
    MODE_SERIAL = 3'h2,
    MODE_DC = 3'h4
  } ldgd_mode_type;

  // ******************************************************************
  // Timing and field layout
  // ******************************************************************
  localparam int PWM_PERIOD = 256;
  localparam int DC_PERIOD = 1280;
  localparam logic [10:0] DC_LAST = 11'(DC_PERIOD - 1);
  localparam int FRAME_BITS = 32;
  localparam int BYTE_A_MSB = 31;
  localparam int BYTE_B_MSB = 23;
  localparam int BYTE_C_MSB = 15;
  localparam int BYTE_D_MSB = 7;
  localparam logic [7:0] DUTY_RESET = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] CODE_ONE = 8'h01;
  localparam logic [7:0] CODE_TWO = 8'h02;
  localparam logic [3:0] CASC_RISE = 4'h7;
  localparam logic [3:0] CASC_LAST = 4'hF;
  localparam int FIFO_DEPTH_DEF = 32;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } ldgd_duty_type;

  typedef struct packed {
    ldgd_mode_type mode;
    logic [7:0] pwm_cnt;
    logic [FRAME_BITS-1:0] shift;
    ldgd_duty_type duty;
    logic [10:0] dc_cnt;
    logic prev_clk;
    logic prev_eof;
    logic [5:0] chan_on;
    logic casc_busy;
    logic [3:0] casc_cnt;
    logic casc_clk;
    logic sync_out;
    logic serial_ready;
  } ldgd_state_type;
endpackage

`timescale 1ns/1ps
module ldgd_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);
  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("ldgd_fifo: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic load;

  // Output word sits in a register; the array only holds what is behind it
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign push = i_valid && o_ready;
  assign load = (count != '0) && (!o_valid || i_ready);

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (load) begin
        o_data <= mem[rd_ptr];
        rd_ptr <= rd_ptr + 1'b1;
      end
      o_valid <= load || (o_valid && !i_ready);
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end
endmodule

// [tb_top.sv]
/*
  Self-checking bench for the LED group dimming block in its three modes.
  Assumes the controller model drives the dimming pins and the bench drives
  reset, strap and converted levels on the falling edge.
*/
`timescale 1ns/1ps
module tb_top;
  import ldgd_pkg::*;
  // Time is compressed: the slow recommended dimming rates are not kept
  localparam int HOLD_CYC = 2000;
  localparam int TMO_CYC = 40000;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [1:0] i_mode_strap = STRAP_GND;
  ldgd_duty_type i_dc_level = '0;
  logic pin_a, pin_b, pin_c, pin_d;
  logic [5:0] o_channel_on;
  logic o_sync_out, o_cascade_clock_output, o_serial_ready;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  int tmo = 0;
  logic [8:0] on_cnt [6];

  always #2 i_clock = ~i_clock;

  ldgd_ctrl_model u_ctrl (
    .i_clock(i_clock),
    .o_pin_a(pin_a),
    .o_pin_b(pin_b),
    .o_pin_c(pin_c),
    .o_pin_d(pin_d)
  );

  ldgd_dimming #(.FIFO_DEPTH(32)) u_dut (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_mode_strap(i_mode_strap),
    .i_group_a_dimming_input(pin_a),
    .i_group_b_dimming_input(pin_b),
    .i_group_c_dimming_input(pin_c),
    .i_group_d_dimming_input(pin_d),
    .i_dc_level(i_dc_level),
    .o_channel_on(o_channel_on),
    .o_sync_out(o_sync_out),
    .o_cascade_clock_output(o_cascade_clock_output),
    .o_serial_ready(o_serial_ready)
  );

  // ******************************************************************
  // Shared helpers
  // ******************************************************************
  always @(negedge i_clock) begin
    cyc++;
    tmo++;
    if (tmo == TMO_CYC) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [8:0] exp_on(input logic [7:0] c);
    if (c == 8'h00) return 9'h000;
    if (c == 8'h01 || c == 8'h02) return 9'h002;
    return 9'(c) + 9'h001;
  endfunction

  task automatic do_reset(input logic [1:0] s);
    @(negedge i_clock);
    i_sys_rst = 1'b1;
    i_mode_strap = s;
    repeat (2) @(negedge i_clock);
    i_sys_rst = 1'b0;
    cyc = 0;
    chk("channels in reset", 32'h0, o_channel_on);
    chk("ready in reset", 32'h0, o_serial_ready);
  endtask

  // A full period of on-cycles is phase independent
  task automatic chk_duty(input ldgd_duty_type d, input string what);
    logic [7:0] code [6];
    code = '{d.a, d.a, d.b, d.b, d.c, d.d};
    repeat (4) @(negedge i_clock);
    for (int k = 0; k < 6; k++) on_cnt[k] = '0;
    repeat (PWM_PERIOD) begin
      @(negedge i_clock);
      for (int k = 0; k < 6; k++) if (o_channel_on[k] === 1'b1) on_cnt[k]++;
    end
    for (int k = 0; k < 6; k++) chk(what, exp_on(code[k]), on_cnt[k]);
  endtask

  task automatic wait_cyc(input int n);
    while (cyc < n) @(negedge i_clock);
  endtask

  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_direct();
    logic [3:0] pat [6];
    pat = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hF, 4'h0};
    do_reset(STRAP_GND);
    foreach (pat[i]) begin
      u_ctrl.drive_direct(pat[i]);
      repeat (2) @(negedge i_clock);
      chk("direct", {pat[i][3], pat[i][2], {2{pat[i][1]}}, {2{pat[i][0]}}}, o_channel_on);
      repeat (HOLD_CYC) @(negedge i_clock);
    end
    // Unused strap code falls back to direct
    do_reset(2'h3);
    u_ctrl.drive_direct(4'h9);
    repeat (2) @(negedge i_clock);
    chk("strap three", 32'h23, o_channel_on);
    repeat (HOLD_CYC) @(negedge i_clock);
    u_ctrl.drive_direct(4'h0);
  endtask

  task automatic t_serial();
    ldgd_duty_type f1;
    ldgd_duty_type f2;
    logic [31:0] seen;
    logic pc;
    logic full;
    int nb;
    f1 = '{8'h00, 8'h01, 8'h02, 8'hFF};
    f2 = '{8'h80, 8'hFE, 8'h03, 8'h01};
    seen = '0;
    pc = 1'b0;
    full = 1'b0;
    nb = 0;
    do_reset(STRAP_OPEN);
    chk_duty('0, "serial unloaded");
    // Bits arrive every 2 cycles while the cascade drains one every 17, eight and a half times slower
    fork
      begin
        u_ctrl.shift_word(f1);
        u_ctrl.end_frame();
        u_ctrl.shift_word(f2);
      end
      for (int t = 0; t < 1500 && nb < 32; t++) begin
        @(negedge i_clock);
        if (o_serial_ready === 1'b0) full = 1'b1;
        if (pc === 1'b0 && o_cascade_clock_output === 1'b1) begin
          seen = {seen[30:0], o_sync_out};
          nb++;
        end
        pc = o_cascade_clock_output;
      end
    join
    chk("cascade bits", f1, seen);
    chk("fifo refused", 32'h1, full);
    chk_duty(f1, "frame one held");
    u_ctrl.end_frame();
    chk_duty(f2, "frame two");
  endtask

  task automatic t_dc();
    ldgd_duty_type l1;
    ldgd_duty_type l2;
    l1 = '{8'h10, 8'hFF, 8'h00, 8'h02};
    l2 = '{8'hC0, 8'h01, 8'h7F, 8'h00};
    i_dc_level = l1;
    do_reset(STRAP_VCC);
    wait_cyc(100);
    chk_duty('0, "dc before update");
    wait_cyc(1400);
    chk_duty(l1, "dc first update");
    // Level changes once, between two updates
    i_dc_level = l2;
    chk_duty(l1, "dc held");
    wait_cyc(2700);
    chk_duty(l2, "dc second update");
  endtask

  initial begin
    t_direct();
    t_serial();
    t_dc();
    summarize();
  end
endmodule
